// ===== rcr_defs.svh
// constants of the remote command request frame and its response
// ----------------------------------------------------------------
// Function
// [RULE1] delimiter 0x7e, then length msb first
// [RULE2] offset 3 holds request type 0x17
// [RULE3] correlation id zero means no response
// [RULE4] sender puts 64-bit destination msb first
// [RULE5] broadcast destination accepted besides node addresses
// [RULE6] reserved bytes sent as 0xff then 0xfe
// [RULE7] options bit 0x02 applies value at once
// [RULE8] sender clears every other options bit
// [RULE9] without apply bit the value stays pending
// [RULE10] command name at 16-17, value from 18
// [RULE11] no value bytes means read request
// [RULE12] checksum is 0xff minus byte sum
// [RULE13] bad checksum or length frames are dropped
// [RULE14] status low nibble result, 0x80 marks remote
// ----------------------------------------------------------------
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH

`define RCR_DELIM 8'h7e
`define RCR_TYPE_REQ 8'h17
`define RCR_TYPE_RSP 8'h88
`define RCR_RSV_HI 8'hff
`define RCR_RSV_LO 8'hfe
`define RCR_OPT_APPLY 8'h02
`define RCR_REMOTE 4'h8
`define RCR_BCAST 64'h0000_0000_0000_ffff
// body bytes from type through the command name
`define RCR_FIXED_LEN 16'h000f
`define RCR_RSP_LEN 16'h0005
// frame offsets
`define RCR_OFS_LENH 8'h01
`define RCR_OFS_LENL 8'h02
`define RCR_OFS_TYPE 8'h03
`define RCR_OFS_ID 8'h04
`define RCR_OFS_ADDR0 8'h05
`define RCR_OFS_ADDR7 8'h0c
`define RCR_OFS_RSV0 8'h0d
`define RCR_OFS_RSV1 8'h0e
`define RCR_OFS_OPT 8'h0f
`define RCR_OFS_CMD0 8'h10
`define RCR_OFS_CMD1 8'h11
`define RCR_OFS_PARAM 8'h12
// response offsets
`define RCR_ROFS_ID 4'h4
`define RCR_ROFS_CMD0 4'h5
`define RCR_ROFS_CMD1 4'h6
`define RCR_ROFS_STAT 4'h7
`define RCR_ROFS_DATA 4'h8
// status codes
`define RCR_ST_OK 4'h0
`define RCR_ST_ERR 4'h1
`define RCR_ST_BADCMD 4'h2
`define RCR_ST_BADPRM 4'h3

`endif

// ===== rcr_pkg.sv
// types and checksum helpers shared by both ends
package rcr_pkg;

  typedef enum logic [4:0] {
    rcr_rx_idle = 5'b00001,
    rcr_rx_lenh = 5'b00010,
    rcr_rx_lenl = 5'b00100,
    rcr_rx_body = 5'b01000,
    rcr_rx_csum = 5'b10000
  } rcr_rx_e;

  typedef enum logic [2:0] {
    rcr_dev_parse = 3'b001,
    rcr_dev_wait = 3'b010,
    rcr_dev_send = 3'b100
  } rcr_dev_e;

  typedef enum logic [1:0] {
    rcr_tx_idle = 2'b01,
    rcr_tx_send = 2'b10
  } rcr_tx_e;

  function automatic logic [7:0] rcr_csum(input logic [7:0] sum);
    return 8'hff - sum;
  endfunction

  function automatic logic rcr_csum_ok(input logic [7:0] sum, input logic [7:0] c);
    return c == rcr_csum(sum);
  endfunction

endpackage

// ===== rcr_link_if.sv
// byte-serial link between host controller and module
interface rcr_link_if;
  logic [7:0] h2d_data;
  logic h2d_valid;
  logic h2d_ready;
  logic [7:0] d2h_data;
  logic d2h_valid;
  logic d2h_ready;

  modport host (
    output h2d_data, h2d_valid, d2h_ready,
    input h2d_ready, d2h_data, d2h_valid
  );

  modport dev (
    input h2d_data, h2d_valid, d2h_ready,
    output h2d_ready, d2h_data, d2h_valid
  );
endinterface

// ===== rcr_dev.sv
// module end: parses request frames, builds command responses
`include "rcr_defs.svh"

module rcr_dev #(
  parameter int MAXP = 8,
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rstn,
  rcr_link_if.dev lnk,
  output logic cmd_valid,
  output logic [7:0] cmd_id,
  output logic [63:0] cmd_addr,
  output logic cmd_bcast,
  output logic [15:0] cmd_name,
  output logic cmd_write,
  output logic cmd_apply,
  output logic [$clog2(MAXP+1)-1:0] cmd_plen,
  output logic [8*MAXP-1:0] cmd_param,
  input wire logic ans_valid,
  output logic ans_ready,
  input wire logic [3:0] ans_status,
  input wire logic ans_has_data,
  input wire logic [7:0] ans_data
);

  localparam int PW = $clog2(MAXP+1);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [15:0] MAXLEN = `RCR_FIXED_LEN + 16'(MAXP);

  // ----------------------------------------------------------------
  // receive framing
  // ----------------------------------------------------------------
  rcr_pkg::rcr_rx_e rx;
  rcr_pkg::rcr_dev_e dst;
  logic rx_ready;
  logic [15:0] len;
  logic [15:0] bcnt;
  logic [7:0] acc;
  logic [7:0] typ;
  logic [7:0] ofs;
  logic take;
  logic good;
  logic [7:0] b;

  assign b = lnk.h2d_data;
  assign take = lnk.h2d_valid && rx_ready;
  assign ofs = bcnt[7:0] + `RCR_OFS_TYPE;
  assign lnk.h2d_ready = rx_ready;

  // a frame counts only if checksum, length bounds and type all agree
  assign good = take && rx == rcr_pkg::rcr_rx_csum
    && rcr_pkg::rcr_csum_ok(acc, b) // RULE12 RULE13
    && len >= `RCR_FIXED_LEN && len <= MAXLEN // RULE13
    && typ == `RCR_TYPE_REQ; // RULE2

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx <= rcr_pkg::rcr_rx_idle;
      len <= 16'h0000;
      bcnt <= 16'h0000;
      acc <= 8'h00;
    end else if (take) begin
      case (rx)
        rcr_pkg::rcr_rx_idle: begin
          if (b == `RCR_DELIM) begin // RULE1
            rx <= rcr_pkg::rcr_rx_lenh;
          end
        end
        rcr_pkg::rcr_rx_lenh: begin
          len[15:8] <= b; // RULE1
          rx <= rcr_pkg::rcr_rx_lenl;
        end
        rcr_pkg::rcr_rx_lenl: begin
          len[7:0] <= b;
          bcnt <= 16'h0000;
          acc <= 8'h00;
          rx <= ({len[15:8], b} == 16'h0000) ? rcr_pkg::rcr_rx_csum
                                             : rcr_pkg::rcr_rx_body;
        end
        rcr_pkg::rcr_rx_body: begin
          acc <= acc + b; // RULE12
          bcnt <= bcnt + 16'h0001;
          // length decides where the checksum falls
          if (bcnt + 16'h0001 == len) begin // RULE1
            rx <= rcr_pkg::rcr_rx_csum;
          end
        end
        rcr_pkg::rcr_rx_csum: begin
          rx <= rcr_pkg::rcr_rx_idle;
        end
        default: begin
          rx <= rcr_pkg::rcr_rx_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // field capture
  // ----------------------------------------------------------------
  // fields are stable only with cmd_valid; the next frame overwrites them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      typ <= 8'h00;
      cmd_id <= 8'h00;
      cmd_addr <= 64'h0;
      cmd_name <= 16'h0000;
      cmd_apply <= 1'b0;
      cmd_param <= '0;
    end else if (take && rx == rcr_pkg::rcr_rx_body && bcnt < MAXLEN) begin
      case (ofs)
        `RCR_OFS_TYPE: typ <= b; // RULE2
        `RCR_OFS_ID: cmd_id <= b; // RULE3
        `RCR_OFS_OPT: cmd_apply <= (b & `RCR_OPT_APPLY) != 8'h00; // RULE7 RULE9
        `RCR_OFS_CMD0: cmd_name[15:8] <= b; // RULE10
        `RCR_OFS_CMD1: cmd_name[7:0] <= b; // RULE10
        default: begin
          if (ofs >= `RCR_OFS_ADDR0 && ofs <= `RCR_OFS_ADDR7) begin
            cmd_addr <= {cmd_addr[55:0], b};
          end else if (ofs >= `RCR_OFS_PARAM) begin
            cmd_param[8*int'(ofs - `RCR_OFS_PARAM) +: 8] <= b; // RULE10
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_valid <= 1'b0;
      cmd_bcast <= 1'b0;
      cmd_write <= 1'b0;
      cmd_plen <= '0;
    end else begin
      cmd_valid <= good;
      if (good) begin
        cmd_bcast <= cmd_addr == `RCR_BCAST; // RULE5
        cmd_write <= len != `RCR_FIXED_LEN; // RULE11
        cmd_plen <= PW'(len - `RCR_FIXED_LEN); // RULE10
      end
    end
  end

  // ----------------------------------------------------------------
  // response buffer
  // ----------------------------------------------------------------
  // shift buffer keeps the head in a flop so the link output is registered
  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0] cnt;
  logic [CW-1:0] wpos;
  logic bvld;
  logic push;
  logic push_ok;
  logic pop;
  logic [WIDTH-1:0] din;

  assign push_ok = cnt < CW'(DEPTH);
  assign pop = bvld && lnk.d2h_ready;
  assign wpos = pop ? cnt - CW'(1) : cnt;
  assign lnk.d2h_data = mem[0];
  assign lnk.d2h_valid = bvld;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      bvld <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      cnt <= cnt + CW'(push && push_ok) - CW'(pop);
      bvld <= (cnt + CW'(push && push_ok) - CW'(pop)) != '0;
      for (int i = 0; i < DEPTH; i++) begin
        if (push && push_ok && i == int'(wpos)) begin
          mem[i] <= din;
        end else if (pop && i < DEPTH - 1) begin
          mem[i] <= mem[i+1];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // request handling and response build
  // ----------------------------------------------------------------
  logic [3:0] ridx;
  logic [3:0] rlast;
  logic [7:0] racc;
  logic [3:0] rstat;
  logic rhas;
  logic [7:0] rdata;

  assign rlast = rhas ? 4'h9 : 4'h8;
  assign push = dst == rcr_pkg::rcr_dev_send;

  always_comb begin
    case (ridx)
      4'h0: din = `RCR_DELIM; // RULE1
      4'h1: din = 8'h00;
      4'h2: din = 8'(`RCR_RSP_LEN) + {7'h00, rhas}; // RULE1
      4'h3: din = `RCR_TYPE_RSP;
      `RCR_ROFS_ID: din = cmd_id;
      `RCR_ROFS_CMD0: din = cmd_name[15:8];
      `RCR_ROFS_CMD1: din = cmd_name[7:0];
      `RCR_ROFS_STAT: din = {`RCR_REMOTE, rstat}; // RULE14
      default: din = (ridx == `RCR_ROFS_DATA && rhas) ? rdata
                                                      : rcr_pkg::rcr_csum(racc); // RULE12
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dst <= rcr_pkg::rcr_dev_parse;
      rx_ready <= 1'b0;
      ans_ready <= 1'b0;
      ridx <= 4'h0;
      racc <= 8'h00;
      rstat <= `RCR_ST_OK;
      rhas <= 1'b0;
      rdata <= 8'h00;
    end else begin
      case (dst)
        rcr_pkg::rcr_dev_parse: begin
          rx_ready <= 1'b1;
          // id zero: the request is acted on but never answered
          if (good && cmd_id != 8'h00) begin // RULE3
            rx_ready <= 1'b0;
            ans_ready <= 1'b1;
            dst <= rcr_pkg::rcr_dev_wait;
          end
        end
        rcr_pkg::rcr_dev_wait: begin
          if (ans_valid) begin
            ans_ready <= 1'b0;
            rstat <= ans_status; // RULE14
            rhas <= ans_has_data;
            rdata <= ans_data;
            ridx <= 4'h0;
            racc <= 8'h00;
            dst <= rcr_pkg::rcr_dev_send;
          end
        end
        rcr_pkg::rcr_dev_send: begin
          if (push_ok) begin
            ridx <= ridx + 4'h1;
            if (ridx >= 4'h3) begin
              racc <= racc + din; // RULE12
            end
            if (ridx == rlast) begin
              rx_ready <= 1'b1;
              dst <= rcr_pkg::rcr_dev_parse;
            end
          end
        end
        default: begin
          dst <= rcr_pkg::rcr_dev_parse;
        end
      endcase
    end
  end

endmodule // rcr_dev

// ===== rcr_host.sv
// host end: frames remote command requests, parses responses
`include "rcr_defs.svh"

module rcr_host #(
  parameter int MAXP = 8
) (
  input wire logic clk,
  input wire logic rstn,
  rcr_link_if.host lnk,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_id,
  input wire logic [63:0] req_addr,
  input wire logic req_apply,
  input wire logic [15:0] req_cmd,
  input wire logic [$clog2(MAXP+1)-1:0] req_plen,
  input wire logic [8*MAXP-1:0] req_param,
  output logic rsp_valid,
  output logic [7:0] rsp_id,
  output logic [15:0] rsp_cmd,
  output logic [7:0] rsp_status,
  output logic rsp_has_data,
  output logic [7:0] rsp_data
);

  // ----------------------------------------------------------------
  // request transmit
  // ----------------------------------------------------------------
  rcr_pkg::rcr_tx_e tx;
  logic [7:0] id;
  logic [63:0] addr;
  logic apply;
  logic [15:0] cmd;
  logic [8*MAXP-1:0] prm;
  logic [7:0] tidx;
  logic [7:0] tlast;
  logic [7:0] tacc;
  logic [7:0] tb;
  logic [15:0] tlen;
  logic tvld;
  logic [7:0] tdata;
  logic adv;

  assign tlen = `RCR_FIXED_LEN + 16'(req_plen);
  assign adv = !tvld || lnk.h2d_ready;
  assign lnk.h2d_valid = tvld;
  assign lnk.h2d_data = tdata;

  always_comb begin
    case (tidx)
      8'h00: tb = `RCR_DELIM; // RULE1
      `RCR_OFS_LENH: tb = 8'h00;
      `RCR_OFS_LENL: tb = tlast - `RCR_OFS_TYPE; // RULE1
      `RCR_OFS_TYPE: tb = `RCR_TYPE_REQ; // RULE2
      `RCR_OFS_ID: tb = id;
      `RCR_OFS_RSV0: tb = `RCR_RSV_HI; // RULE6
      `RCR_OFS_RSV1: tb = `RCR_RSV_LO; // RULE6
      `RCR_OFS_OPT: tb = apply ? `RCR_OPT_APPLY : 8'h00; // RULE7 RULE8
      `RCR_OFS_CMD0: tb = cmd[15:8]; // RULE10
      `RCR_OFS_CMD1: tb = cmd[7:0];
      default: begin
        if (tidx <= `RCR_OFS_ADDR7) begin
          tb = addr[8*int'(`RCR_OFS_ADDR7 - tidx) +: 8]; // RULE4
        end else if (tidx == tlast) begin
          tb = rcr_pkg::rcr_csum(tacc); // RULE12
        end else begin
          tb = prm[8*int'(tidx - `RCR_OFS_PARAM) +: 8]; // RULE10
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx <= rcr_pkg::rcr_tx_idle;
      req_ready <= 1'b0;
      id <= 8'h00;
      addr <= 64'h0;
      apply <= 1'b0;
      cmd <= 16'h0000;
      prm <= '0;
      tidx <= 8'h00;
      tlast <= 8'h00;
      tacc <= 8'h00;
      tvld <= 1'b0;
      tdata <= 8'h00;
    end else begin
      case (tx)
        rcr_pkg::rcr_tx_idle: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            id <= req_id;
            addr <= req_addr;
            apply <= req_apply;
            cmd <= req_cmd;
            prm <= req_param;
            tidx <= 8'h00;
            tacc <= 8'h00;
            tlast <= tlen[7:0] + `RCR_OFS_TYPE;
            tx <= rcr_pkg::rcr_tx_send;
          end
        end
        rcr_pkg::rcr_tx_send: begin
          if (adv) begin
            if (tidx <= tlast) begin
              tvld <= 1'b1;
              tdata <= tb;
              tidx <= tidx + 8'h01;
              if (tidx >= `RCR_OFS_TYPE) begin
                tacc <= tacc + tb; // RULE12
              end
            end else begin
              tvld <= 1'b0;
              tx <= rcr_pkg::rcr_tx_idle;
            end
          end
        end
        default: begin
          tx <= rcr_pkg::rcr_tx_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // response receive
  // ----------------------------------------------------------------
  rcr_pkg::rcr_rx_e rx;
  logic rrdy;
  logic take;
  logic [7:0] b;
  logic [15:0] len;
  logic [3:0] ofs;
  logic [7:0] racc;
  logic [7:0] rtyp;

  assign b = lnk.d2h_data;
  assign take = lnk.d2h_valid && rrdy;
  assign lnk.d2h_ready = rrdy;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx <= rcr_pkg::rcr_rx_idle;
      rrdy <= 1'b0;
      len <= 16'h0000;
      ofs <= 4'h0;
      racc <= 8'h00;
      rtyp <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_id <= 8'h00;
      rsp_cmd <= 16'h0000;
      rsp_status <= 8'h00;
      rsp_has_data <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      rrdy <= 1'b1;
      rsp_valid <= 1'b0;
      if (take) begin
        case (rx)
          rcr_pkg::rcr_rx_idle: if (b == `RCR_DELIM) rx <= rcr_pkg::rcr_rx_lenh;
          rcr_pkg::rcr_rx_lenh: begin
            len[15:8] <= b;
            rx <= rcr_pkg::rcr_rx_lenl;
          end
          rcr_pkg::rcr_rx_lenl: begin
            len[7:0] <= b;
            ofs <= 4'h3;
            racc <= 8'h00;
            // only 5 or 6 byte bodies are answers we understand
            rx <= ({len[15:8], b} == `RCR_RSP_LEN || {len[15:8], b} == `RCR_RSP_LEN + 16'h0001)
                  ? rcr_pkg::rcr_rx_body : rcr_pkg::rcr_rx_idle;
          end
          rcr_pkg::rcr_rx_body: begin
            racc <= racc + b;
            ofs <= ofs + 4'h1;
            case (ofs)
              4'h3: rtyp <= b;
              `RCR_ROFS_ID: rsp_id <= b;
              `RCR_ROFS_CMD0: rsp_cmd[15:8] <= b;
              `RCR_ROFS_CMD1: rsp_cmd[7:0] <= b;
              `RCR_ROFS_STAT: rsp_status <= b;
              default: rsp_data <= b;
            endcase
            if (16'(ofs) - 16'h0002 == len) rx <= rcr_pkg::rcr_rx_csum;
          end
          rcr_pkg::rcr_rx_csum: begin
            rx <= rcr_pkg::rcr_rx_idle;
            rsp_valid <= rcr_pkg::rcr_csum_ok(racc, b) && rtyp == `RCR_TYPE_RSP; // RULE12
            rsp_has_data <= len != `RCR_RSP_LEN;
          end
          default: rx <= rcr_pkg::rcr_rx_idle;
        endcase
      end
    end
  end

endmodule // rcr_host

// ===== rcr_props.sv
// link-level checker for the host/module byte link
module rcr_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] h2d_data,
  input wire logic h2d_valid,
  input wire logic h2d_ready,
  input wire logic [7:0] d2h_data,
  input wire logic d2h_valid,
  input wire logic d2h_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic h_take, d_take, h_last, d_last;
  logic [7:0] h_idx, h_len, h_sum, h_id, d_idx, d_len, d_sum;
  // ----------------------------------------------------------------
  // byte position trackers
  // ----------------------------------------------------------------
  assign h_take = h2d_valid && h2d_ready;
  assign d_take = d2h_valid && d2h_ready;
  // frames end by length, not by valid dropping, so gaps cannot confuse the count
  assign h_last = h_take && h_idx > 8'h02 && h_idx == h_len + 8'h03;
  assign d_last = d_take && d_idx > 8'h02 && d_idx == d_len + 8'h03;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      h_idx <= 8'h00;
      h_len <= 8'h00;
      h_sum <= 8'h00;
      h_id <= 8'h00;
    end else if (h_take) begin
      h_idx <= h_last ? 8'h00 : h_idx + 8'h01;
      h_len <= (h_idx == 8'h02) ? h2d_data : h_len;
      h_id <= (h_idx == 8'h04) ? h2d_data : h_id;
      h_sum <= (h_idx == 8'h03) ? h2d_data : h_sum + h2d_data;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      d_idx <= 8'h00;
      d_len <= 8'h00;
      d_sum <= 8'h00;
    end else if (d_take) begin
      d_idx <= d_last ? 8'h00 : d_idx + 8'h01;
      d_len <= (d_idx == 8'h02) ? d2h_data : d_len;
      d_sum <= (d_idx == 8'h03) ? d2h_data : d_sum + d2h_data;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence h_byte(int n);
    h_take && h_idx == n;
  endsequence
  sequence d_byte(int n);
    d_take && d_idx == n;
  endsequence
  a_h_delim_len: assert property (h_byte(0) |-> h2d_data == 8'h7e ##1 h2d_data == 8'h00)
    else $error("request frame start wrong");
  a_h_frame_end: assert property (h_last |=> !h2d_valid)
    else $error("request runs past its length");
  a_h_type: assert property (h_byte(3) |-> h2d_data == 8'h17)
    else $error("request type wrong");
  a_h_reserved: assert property (h_byte(13) |-> h2d_data == 8'hff ##1 h2d_data == 8'hfe)
    else $error("reserved bytes wrong");
  a_h_options: assert property (h_byte(15) |-> (h2d_data & 8'hfd) == 8'h00)
    else $error("option bits other than apply set");
  a_h_checksum: assert property (h_last |-> h2d_data == 8'hff - h_sum)
    else $error("request checksum wrong");
  a_h_hold_byte: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
    else $error("request byte changed before taken");
  a_no_reply: assert property (h_last && h_id == 8'h00 |=> !d2h_valid [*8])
    else $error("response sent for zero id");
  a_reply_id: assert property (d_byte(4) |-> d2h_data == h_id && h_id != 8'h00)
    else $error("response id mismatch");
  a_d_type_len: assert property (d_byte(2) |-> d2h_data inside {8'h05, 8'h06}
    ##1 d2h_data == 8'h88)
    else $error("response length or type wrong");
  a_d_status: assert property (d_byte(7) |-> d2h_data[7:4] == 4'h8 && d2h_data[3:0] < 4'h4)
    else $error("response status wrong");
  a_d_checksum: assert property (d_last |-> d2h_data == 8'hff - d_sum)
    else $error("response checksum wrong");
endmodule // rcr_props

// ===== tb.sv
// testbench: host and module ends joined, plus a module end driven by hand
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, req_valid = 0, req_apply = 0, ans_valid = 0, ans_has_data = 0;
  logic req_ready, rsp_valid, rsp_has_data, cmd_valid, cmd_bcast, cmd_write, cmd_apply;
  logic ans_ready, ans_ready2, cmd_valid2;
  logic [7:0] req_id = 0, ans_data = 0, rsp_id, rsp_status, rsp_data, cmd_id;
  logic [3:0] req_plen = 0, ans_status = 0, cmd_plen;
  logic [15:0] req_cmd = 0, rsp_cmd, cmd_name;
  logic [63:0] req_addr = 0, req_param = 0, cmd_addr, cmd_param;
  int err_count = 0, comparisons = 0, n2 = 0;
  rcr_link_if lnk ();
  rcr_link_if lnk2 ();
  rcr_host i_rcr_host (.clk(clk), .rstn(rstn), .lnk(lnk.host), .req_valid(req_valid),
    .req_ready(req_ready), .req_id(req_id), .req_addr(req_addr), .req_apply(req_apply),
    .req_cmd(req_cmd), .req_plen(req_plen), .req_param(req_param), .rsp_valid(rsp_valid),
    .rsp_id(rsp_id), .rsp_cmd(rsp_cmd), .rsp_status(rsp_status),
    .rsp_has_data(rsp_has_data), .rsp_data(rsp_data));
  rcr_dev i_rcr_dev (.clk(clk), .rstn(rstn), .lnk(lnk.dev), .cmd_valid(cmd_valid),
    .cmd_id(cmd_id), .cmd_addr(cmd_addr), .cmd_bcast(cmd_bcast), .cmd_name(cmd_name),
    .cmd_write(cmd_write), .cmd_apply(cmd_apply), .cmd_plen(cmd_plen), .cmd_param(cmd_param),
    .ans_valid(ans_valid), .ans_ready(ans_ready), .ans_status(ans_status),
    .ans_has_data(ans_has_data), .ans_data(ans_data));
  // second module end faces the bench, which breaks the framing on purpose
  rcr_dev i_rcr_dev_2 (.clk(clk), .rstn(rstn), .lnk(lnk2.dev), .cmd_valid(cmd_valid2),
    .cmd_id(), .cmd_addr(), .cmd_bcast(), .cmd_name(), .cmd_write(), .cmd_apply(),
    .cmd_plen(), .cmd_param(), .ans_valid(ans_valid), .ans_ready(ans_ready2),
    .ans_status(ans_status), .ans_has_data(ans_has_data), .ans_data(ans_data));
  rcr_props i_rcr_props (.clk(clk), .rstn(rstn), .h2d_data(lnk.h2d_data),
    .h2d_valid(lnk.h2d_valid), .h2d_ready(lnk.h2d_ready), .d2h_data(lnk.d2h_data),
    .d2h_valid(lnk.d2h_valid), .d2h_ready(lnk.d2h_ready));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cmd_valid2 === 1'b1) n2++;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // waits until a handshake level is high, then lets the taking edge pass
  task automatic handshake(ref logic rdy);
    int t;
    t = 0;
    while (rdy !== 1'b1 && t < 300) begin
      @(posedge clk);
      #1;
      t++;
    end
    if (t >= 300) chk("handshake", 1, 0);
    @(posedge clk);
    #1;
  endtask
  task automatic req(input logic [7:0] id, input logic [63:0] a, input logic ap,
    input logic [15:0] c, input logic [3:0] n);
    req_valid = 1;
    req_id = id;
    req_addr = a;
    req_apply = ap;
    req_cmd = c;
    req_plen = n;
    req_param = 64'hf1e2_d3c4_b5a6_9788;
    handshake(req_ready);
    req_valid = 0;
  endtask
  task automatic ans(input logic sel, input logic [3:0] st, input logic hd,
    input logic [7:0] d);
    ans_valid = 1;
    ans_status = st;
    ans_has_data = hd;
    ans_data = d;
    if (sel) handshake(ans_ready2);
    else handshake(ans_ready);
    ans_valid = 0;
  endtask
  task automatic put2(input logic [7:0] b);
    lnk2.h2d_data = b;
    lnk2.h2d_valid = 1;
    handshake(lnk2.h2d_ready);
  endtask
  task automatic frame2(input logic [7:0] id, input logic [7:0] bad);
    logic [7:0] b[16] = '{8'h17, id, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
      8'hff, 8'hff, 8'hfe, 8'h00, 8'h41, 8'h42, 8'h07};
    logic [7:0] s;
    s = 0;
    put2(8'h7e);
    put2(8'h00);
    put2(8'h10);
    foreach (b[i]) begin
      put2(b[i]);
      s += b[i];
    end
    put2((8'hff - s) ^ bad);
  endtask
  task automatic get2(input logic [7:0] exp);
    int t;
    t = 0;
    while (lnk2.d2h_valid !== 1'b1 && t < 100) begin
      @(posedge clk);
      #1;
      t++;
    end
    chk("response byte", exp, lnk2.d2h_data);
    @(posedge clk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    static logic [3:0] plens[4] = '{4'h1, 4'h0, 4'h8, 4'h3};
    logic [63:0] a, m;
    static logic [7:0] rsp[10] = '{8'h7e, 8'h00, 8'h06, 8'h88, 8'h33, 8'h41, 8'h42, 8'h80,
      8'h77,
      8'h00};
    lnk2.h2d_valid = 0;
    lnk2.h2d_data = 0;
    lnk2.d2h_ready = 0;
    repeat (6) @(posedge clk);
    #1;
    rstn = 1;
    req(8'h00, 64'h0001_0203_0405_0607, 1'b1, 16'h4142, 4'h1);
    handshake(cmd_valid);
    chk("cmd id", 8'h00, cmd_id);
    repeat (30) begin
      chk("silent answer", 2'b00, {ans_ready, rsp_valid});
      @(posedge clk);
      #1;
    end
    $display("test zero id done");
    for (int k = 0; k < 4; k++) begin
      a = (k == 1) ? 64'h0000_0000_0000_ffff : 64'h0123_4567_89ab_cde0 + 64'(k);
      m = (plens[k] == 4'h8) ? '1 : (64'h1 << (8 * plens[k])) - 64'h1;
      req(8'h10 + 8'(k), a, k[0], 16'h4241 + 16'(k), plens[k]);
      handshake(cmd_valid);
      chk("cmd addr", a, cmd_addr);
      chk("cmd bcast", k == 1, cmd_bcast);
      chk("cmd apply", k[0], cmd_apply);
      chk("cmd name", 16'h4241 + 16'(k), cmd_name);
      chk("cmd plen", plens[k], cmd_plen);
      chk("cmd param", 64'hf1e2_d3c4_b5a6_9788 & m, cmd_param & m);
      chk("cmd write", plens[k] != 4'h0, cmd_write);
      ans(1'b0, 4'(k), k[1], 8'h5a + 8'(k));
      handshake(rsp_valid);
      chk("rsp id", 8'h10 + 8'(k), rsp_id);
      chk("rsp cmd", 16'h4241 + 16'(k), rsp_cmd);
      chk("rsp status", 8'h80 + 8'(k), rsp_status);
      chk("rsp has data", k[1], rsp_has_data);
      if (k[1]) chk("rsp data", 8'h5a + 8'(k), rsp_data);
      $display("test status code %0d done", k);
    end
    put2(8'h55);
    frame2(8'h00, 8'h01);
    frame2(8'h00, 8'h00);
    frame2(8'h33, 8'h00);
    lnk2.h2d_valid = 0;
    repeat (5) @(posedge clk);
    #1;
    chk("frames accepted", 2, n2);
    ans(1'b1, 4'h0, 1'b1, 8'h77);
    repeat (12) @(posedge clk);
    #1;
    chk("stalled valid", 1, lnk2.d2h_valid);
    rsp[9] = 8'hff - (8'h88 + 8'h33 + 8'h41 + 8'h42 + 8'h80 + 8'h77);
    lnk2.d2h_ready = 1;
    foreach (rsp[i]) get2(rsp[i]);
    repeat (3) @(posedge clk);
    #1;
    chk("drained", 0, lnk2.d2h_valid);
    $display("test bad frame and stall done");
    report_and_stop();
  end
  initial begin
    #200us;
    err_count++;
    report_and_stop();
  end
endmodule // tb
